// ==== design/ir_pulse_classify.v ====
// measures received high pulses and sorts them into single or double
`timescale 1ns/1ps
`default_nettype none

module ir_pulse_classify #(
  parameter W = 6
) (
  input  wire         i_core_clk,
  input  wire         i_rstn,
  input  wire         i_level,
  input  wire [W-1:0] i_single_max,
  output reg          o_single,
  output reg          o_double
);

  reg         prev_q;
  reg [W-1:0] run_q;

  // ************************************************
  // run length and verdict at falling edge
  // ************************************************
  // run saturates so a stuck-high line cannot wrap into a single
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_q   <= 1'b0;
      run_q    <= {W{1'b0}};
      o_single <= 1'b0;
      o_double <= 1'b0;
    end else begin
      prev_q   <= i_level;
      o_single <= 1'b0;
      o_double <= 1'b0;
      if (i_level) begin
        if (run_q != {W{1'b1}}) begin
          run_q <= run_q + {{(W-1){1'b0}}, 1'b1};
        end
      end else begin
        run_q <= {W{1'b0}};
        if (prev_q) begin
          o_single <= (run_q <= i_single_max);
          o_double <= (run_q >  i_single_max);
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/ir_pulse_stretch.v ====
// one-shot pulse of programmable length in reference clock cycles
`timescale 1ns/1ps
`default_nettype none

module ir_pulse_stretch #(
  parameter W = 6
) (
  input  wire         i_core_clk,
  input  wire         i_rstn,
  input  wire         i_start,
  input  wire [W-1:0] i_len,
  output reg          o_pulse
);

  reg [W-1:0] cnt_q;

  // ************************************************
  // pulse counter
  // ************************************************
  // a start during a running pulse is dropped so pulses never merge
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pulse <= 1'b0;
      cnt_q   <= {W{1'b0}};
    end else if (i_start && !o_pulse && (i_len != {W{1'b0}})) begin
      o_pulse <= 1'b1;
      cnt_q   <= i_len - {{(W-1){1'b0}}, 1'b1};
    end else if (o_pulse) begin
      if (cnt_q == {W{1'b0}}) begin
        o_pulse <= 1'b0;
      end else begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/irda_fir_mir_pulse_config.v ====
// pulse configuration registers and pulse shaping for fast and medium infrared
//
// Behaviour
// - fast frame preamble count from 3-bit code; unknown codes give 16
// - fast pulse width code+1 single, code+7 double; 110 and 111 prohibited
// - read-only window code sorts received fast pulses single or double
// - medium pulse lasts width code plus one reference cycles
`timescale 1ns/1ps
`default_nettype none
`include "irda_pulse_defs.vh"

module irda_fir_mir_pulse_config (
  input  wire        i_core_clk,
  input  wire        i_rstn,
  // register port
  input  wire [31:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  // modulator side
  input  wire        i_hdr_start,
  input  wire        i_hdr_mir,
  input  wire        i_hdr_sym_done,
  output reg         o_hdr_busy,
  output reg  [5:0]  o_hdr_left,
  input  wire        i_fir_tx_single,
  input  wire        i_fir_tx_double,
  input  wire        i_mir_tx_pulse,
  output wire        o_ir_tx,
  // receive pin
  input  wire        i_ir_rx,
  output wire        o_rx_single,
  output wire        o_rx_double,
  // decoded settings
  output reg  [5:0]  o_fir_preamble_count,
  output reg  [5:0]  o_fir_single_len,
  output reg  [5:0]  o_fir_double_len,
  output reg  [5:0]  o_mir_start_flag_count,
  output reg  [5:0]  o_mir_pulse_len
);

  // ************************************************
  // decode functions
  // ************************************************
  function [5:0] preamble_count;
    input [2:0] code;
    begin
      case (code)
        3'h1:    preamble_count = `COUNT_1;
        3'h2:    preamble_count = `COUNT_2;
        3'h3:    preamble_count = `COUNT_4;
        3'h4:    preamble_count = `COUNT_16;
        3'h7:    preamble_count = `COUNT_32;
        default: preamble_count = `COUNT_16;
      endcase
    end
  endfunction

  function [5:0] start_flag_count;
    input [2:0] code;
    begin
      case (code)
        3'h1:    start_flag_count = `COUNT_1;
        3'h2:    start_flag_count = `COUNT_2;
        3'h3:    start_flag_count = `COUNT_4;
        3'h4:    start_flag_count = `COUNT_16;
        3'h7:    start_flag_count = `COUNT_32;
        default: start_flag_count = `COUNT_2;
      endcase
    end
  endfunction

  // ************************************************
  // register storage
  // ************************************************
  reg [2:0] preamble_count_code_q;
  reg [2:0] fir_width_code_q;
  reg [2:0] start_flag_count_code_q;
  reg [4:0] mir_width_code_q;

  // window field is hardware-fixed, no write path
  wire [1:0] window_code = `WINDOW_CODE_RST;

  wire sel_fast   = (i_addr == `FAST_IR_PULSE_CONTROL_ADDR);
  wire sel_medium = (i_addr == `MEDIUM_IR_PULSE_CONTROL_ADDR);

  wire [2:0] wr_fir_width = i_wdata[`FIR_WIDTH_MSB:`FIR_WIDTH_LSB];

  // upper byte of a write is dropped
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      preamble_count_code_q   <= `PREAMBLE_CODE_RST;
      fir_width_code_q        <= `FIR_WIDTH_RST;
      start_flag_count_code_q <= `START_FLAG_CODE_RST;
      mir_width_code_q        <= `MIR_WIDTH_RST;
    end else if (i_wr) begin
      if (sel_fast) begin
        preamble_count_code_q <= i_wdata[`PREAMBLE_CODE_MSB:`PREAMBLE_CODE_LSB];
        // prohibited codes keep the old width
        if (wr_fir_width <= `FIR_WIDTH_MAX) begin
          fir_width_code_q <= wr_fir_width;
        end
      end
      if (sel_medium) begin
        start_flag_count_code_q <= i_wdata[`START_FLAG_CODE_MSB:`START_FLAG_CODE_LSB];
        mir_width_code_q        <= i_wdata[`MIR_WIDTH_MSB:`MIR_WIDTH_LSB];
      end
    end
  end

  // ************************************************
  // read port
  // ************************************************
  // data valid only in the cycle after the strobe, zero elsewhere
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else if (i_rd && sel_fast) begin
      o_rdata <= {8'h00, preamble_count_code_q, window_code,
                  fir_width_code_q};
    end else if (i_rd && sel_medium) begin
      o_rdata <= {8'h00, start_flag_count_code_q,
                  mir_width_code_q};
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // ************************************************
  // decoded settings
  // ************************************************
  // registered so the modulator sees settled values one cycle after a write
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fir_preamble_count   <= `COUNT_16;
      o_fir_single_len       <= 6'h06;
      o_fir_double_len       <= 6'h0c;
      o_mir_start_flag_count <= `COUNT_2;
      o_mir_pulse_len        <= 6'h0a;
    end else begin
      o_fir_preamble_count   <= preamble_count(preamble_count_code_q);
      o_fir_single_len       <= {3'h0, fir_width_code_q} + 6'h01;
      o_fir_double_len       <= {3'h0, fir_width_code_q} + `FIR_DOUBLE_EXTRA
                                + 6'h01;
      o_mir_start_flag_count <= start_flag_count(start_flag_count_code_q);
      o_mir_pulse_len        <= {1'b0, mir_width_code_q} + 6'h01;
    end
  end

  // ************************************************
  // header sequencer
  // ************************************************
  // counts preambles or start flags out as the modulator sends them;
  // counts are sampled at frame start, so a later write cannot
  // change the header length of a frame already under way
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hdr_busy <= 1'b0;
      o_hdr_left <= 6'h00;
    end else if (!o_hdr_busy) begin
      if (i_hdr_start) begin
        o_hdr_busy <= 1'b1;
        o_hdr_left <= i_hdr_mir ? o_mir_start_flag_count
                                : o_fir_preamble_count;
      end
    end else if (i_hdr_sym_done) begin
      o_hdr_left <= o_hdr_left - 6'h01;
      if (o_hdr_left == 6'h01) begin
        o_hdr_busy <= 1'b0;
      end
    end
  end

  // ************************************************
  // transmit pulse shaping
  // ************************************************
  reg  [5:0] tx_len;
  wire       tx_start = i_fir_tx_single | i_fir_tx_double | i_mir_tx_pulse;

  // double wins over single if both are asserted together
  always @* begin
    if (i_fir_tx_double) begin
      tx_len = o_fir_double_len;
    end else if (i_fir_tx_single) begin
      tx_len = o_fir_single_len;
    end else begin
      tx_len = o_mir_pulse_len;
    end
  end

  ir_pulse_stretch #(
    .W (6)
  ) u_tx_pulse (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_start    (tx_start),
    .i_len      (tx_len),
    .o_pulse    (o_ir_tx)
  );

  // ************************************************
  // receive classification
  // ************************************************
  reg        rx_meta_q;
  reg        rx_sync_q;
  reg  [5:0] single_max_q;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_meta_q    <= 1'b0;
      rx_sync_q    <= 1'b0;
      single_max_q <= 6'h08;
    end else begin
      rx_meta_q    <= i_ir_rx;
      rx_sync_q    <= rx_meta_q;
      // window base plus window code and below count as single
      single_max_q <= `WINDOW_BASE + {4'h0, window_code};
    end
  end

  ir_pulse_classify #(
    .W (6)
  ) u_rx_class (
    .i_core_clk   (i_core_clk),
    .i_rstn       (i_rstn),
    .i_level      (rx_sync_q),
    .i_single_max (single_max_q),
    .o_single     (o_rx_single),
    .o_double     (o_rx_double)
  );

endmodule

`default_nettype wire

// ==== design/irda_pulse_defs.vh ====
// register map, field layout, reset values and codes of the pulse configuration block
`ifndef IRDA_PULSE_DEFS_VH
`define IRDA_PULSE_DEFS_VH

// ************************************************
// register offsets
// ************************************************
`define FAST_IR_PULSE_CONTROL_ADDR   32'h0c00005e
`define MEDIUM_IR_PULSE_CONTROL_ADDR 32'h0c000060

// ************************************************
// fast infrared control fields
// ************************************************
`define PREAMBLE_CODE_MSB  7
`define PREAMBLE_CODE_LSB  5
`define WINDOW_CODE_MSB    4
`define WINDOW_CODE_LSB    3
`define FIR_WIDTH_MSB      2
`define FIR_WIDTH_LSB      0
`define PREAMBLE_CODE_RST  3'h4
`define WINDOW_CODE_RST    2'h1
`define FIR_WIDTH_RST      3'h5
`define FIR_WIDTH_MAX      3'h5
`define FIR_DOUBLE_EXTRA   6'h06

// ************************************************
// medium infrared control fields
// ************************************************
`define START_FLAG_CODE_MSB 7
`define START_FLAG_CODE_LSB 5
`define MIR_WIDTH_MSB       4
`define MIR_WIDTH_LSB       0
`define START_FLAG_CODE_RST 3'h2
`define MIR_WIDTH_RST       5'h09

// ************************************************
// header counts and receive window
// ************************************************
`define COUNT_1            6'h01
`define COUNT_2            6'h02
`define COUNT_4            6'h04
`define COUNT_16           6'h10
`define COUNT_32           6'h20
`define WINDOW_BASE        6'h07

`endif

// ==== test/ir_transceiver_model.sv ====
// optical transceiver model: emits light pulses and measures transmit pulses
`timescale 1ns/1ps
`default_nettype none

module ir_transceiver_model (
  input  wire logic i_core_clk,
  input  wire logic i_tx_light,
  output logic      o_rx_light
);
  logic [7:0] run_q = 8'h00;
  logic [7:0] last_width = 8'h00;

  // dark line when idle, as a real receiver photodiode shows
  initial o_rx_light = 1'b0;

  always @(posedge i_core_clk) begin
    if (i_tx_light) begin
      run_q <= run_q + 8'h01;
    end else if (run_q != 8'h00) begin
      last_width <= run_q;
      run_q <= 8'h00;
    end
  end

  task automatic light(input int n);
    @(posedge i_core_clk);
    o_rx_light <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    o_rx_light <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== test/irda_fir_mir_pulse_config_assertions.sv ====
// concurrent checks on the pulse configuration block ports
`timescale 1ns/1ps
`default_nettype none
`include "irda_pulse_defs.vh"

module pulse_config_checker (
  input wire logic        i_core_clk,
  input wire logic        i_rstn,
  input wire logic [31:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_hdr_start,
  input wire logic        i_hdr_mir,
  input wire logic        o_hdr_busy,
  input wire logic [5:0]  o_hdr_left,
  input wire logic        i_fir_tx_single,
  input wire logic        i_fir_tx_double,
  input wire logic        o_ir_tx,
  input wire logic        o_rx_single,
  input wire logic        o_rx_double,
  input wire logic [5:0]  o_fir_preamble_count,
  input wire logic [5:0]  o_fir_single_len,
  input wire logic [5:0]  o_fir_double_len,
  input wire logic [5:0]  o_mir_start_flag_count,
  input wire logic [5:0]  o_mir_pulse_len
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_mir_write;
    (i_wr && i_addr == `MEDIUM_IR_PULSE_CONTROL_ADDR)
      ##1 !(i_wr && i_addr == `MEDIUM_IR_PULSE_CONTROL_ADDR);
  endsequence
  sequence s_short_single;
    i_fir_tx_single && !i_fir_tx_double && !o_ir_tx && o_fir_single_len == 6'h01;
  endsequence

  property p_upper_zero; o_rdata[15:8] == 8'h00; endproperty
  property p_window_ro;
    ($past(i_rd) && $past(i_addr) == `FAST_IR_PULSE_CONTROL_ADDR) |-> o_rdata[4:3] == 2'b01;
  endproperty
  property p_double_len; o_fir_double_len == o_fir_single_len + 6'h06; endproperty
  property p_single_range; o_fir_single_len inside {[6'h01:6'h06]}; endproperty
  property p_preamble_set; o_fir_preamble_count inside {1, 2, 4, 16, 32}; endproperty
  property p_start_flag_set; o_mir_start_flag_count inside {1, 2, 4, 16, 32}; endproperty
  property p_mir_len;
    s_mir_write |=> o_mir_pulse_len == {1'b0, $past(i_wdata[4:0], 2)} + 6'h01;
  endproperty
  property p_tx_one; s_short_single |=> o_ir_tx ##1 !o_ir_tx; endproperty
  property p_hdr_load;
    (i_hdr_start && !o_hdr_busy && !i_hdr_mir)
      |=> o_hdr_busy && o_hdr_left == $past(o_fir_preamble_count);
  endproperty
  property p_rx_pulse;
    (o_rx_single || o_rx_double) |-> !(o_rx_single && o_rx_double) ##1 !(o_rx_single || o_rx_double);
  endproperty

  a_upper_zero: assert property (p_upper_zero) else $error("upper read byte not zero");
  a_window_ro: assert property (p_window_ro) else $error("window field not 01");
  a_double_len: assert property (p_double_len) else $error("double width wrong");
  a_single_range: assert property (p_single_range) else $error("single width range");
  a_preamble_set: assert property (p_preamble_set) else $error("preamble count illegal");
  a_start_flag_set: assert property (p_start_flag_set) else $error("start flag illegal");
  a_mir_len: assert property (p_mir_len) else $error("medium width wrong");
  a_tx_one: assert property (p_tx_one) else $error("one cycle pulse wrong");
  a_hdr_load: assert property (p_hdr_load) else $error("header count wrong");
  a_rx_pulse: assert property (p_rx_pulse) else $error("verdict pulse wrong");
endmodule

bind irda_fir_mir_pulse_config pulse_config_checker chk (.*);

`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the pulse configuration block
`timescale 1ns/1ps
`default_nettype none
`include "irda_pulse_defs.vh"

module testbench;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [31:0] i_addr = 32'h0;
  logic [15:0] i_wdata = 16'h0;
  logic i_wr = 0, i_rd = 0, i_hdr_start = 0, i_hdr_mir = 0, i_hdr_sym_done = 0;
  logic i_fir_tx_single = 0, i_fir_tx_double = 0, i_mir_tx_pulse = 0;
  wire [15:0] o_rdata;
  wire o_hdr_busy, o_ir_tx, i_ir_rx, o_rx_single, o_rx_double;
  wire [5:0] o_hdr_left, o_fir_preamble_count, o_fir_single_len, o_fir_double_len;
  wire [5:0] o_mir_start_flag_count, o_mir_pulse_len;
  int bad_count = 0, n_compared = 0, n_single = 0, n_double = 0;
  logic [5:0] pre_tab [8] = '{6'h10, 6'h01, 6'h02, 6'h04, 6'h10, 6'h10, 6'h10, 6'h20};
  logic [5:0] sta_tab [8] = '{6'h02, 6'h01, 6'h02, 6'h04, 6'h10, 6'h02, 6'h02, 6'h20};
  // full and half rate widths sit between the extremes
  logic [4:0] mir_w [4] = '{5'h00, 5'h09, 5'h14, 5'h1f};
  localparam logic [31:0] FA = `FAST_IR_PULSE_CONTROL_ADDR;
  localparam logic [31:0] MA = `MEDIUM_IR_PULSE_CONTROL_ADDR;

  irda_fir_mir_pulse_config uut (.*);
  ir_transceiver_model m (.i_core_clk(i_core_clk), .i_tx_light(o_ir_tx), .o_rx_light(i_ir_rx));

  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    if (o_rx_single === 1'b1) n_single++;
    if (o_rx_double === 1'b1) n_double++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge i_core_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    check(o_rdata, exp);
  endtask
  task automatic settle();
    repeat (2) @(negedge i_core_clk);
  endtask
  // pulse lengths top out at 32, so 40 cycles always sees the fall
  task automatic fire(input int kind, input logic [7:0] exp);
    @(posedge i_core_clk);
    if (kind == 0) i_fir_tx_single <= 1'b1; else if (kind == 1) i_fir_tx_double <= 1'b1;
    else i_mir_tx_pulse <= 1'b1;
    @(posedge i_core_clk);
    {i_fir_tx_single, i_fir_tx_double, i_mir_tx_pulse} <= 3'b000;
    repeat (40) @(negedge i_core_clk);
    check(m.last_width, exp);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #(40 * 8000);
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd(FA, 16'h008d);
    rd(MA, 16'h0049);
    check(o_fir_double_len, 6'h0c);
    $display("reset values done");
    for (int c = 0; c < 8; c++) begin
      wr(FA, {8'h00, 3'(c), 5'h00});
      wr(MA, {8'h00, 3'(c), 5'h00});
      settle();
      check(o_fir_preamble_count, pre_tab[c]);
      check(o_mir_start_flag_count, sta_tab[c]);
    end
    $display("header codes done");
    for (int w = 0; w < 6; w++) begin
      wr(FA, {8'h00, 3'h1, 2'b00, 3'(w)});
      settle();
      check(o_fir_single_len, 6'(w + 1));
      fire(0, 8'(w + 1));
      fire(1, 8'(w + 7));
    end
    // prohibited width, read-only window and upper byte in one write
    wr(FA, 16'hff1e);
    rd(FA, 16'h000d);
    settle();
    check(o_fir_single_len, 6'h06);
    wr(32'h0c000062, 16'h00ff);
    rd(32'h0c000062, 16'h0000);
    rd(MA, 16'h00e0);
    $display("fast width done");
    for (int i = 0; i < 4; i++) begin
      wr(MA, {8'h00, 3'h2, mir_w[i]});
      settle();
      check(o_mir_pulse_len, {1'b0, mir_w[i]} + 6'h01);
      fire(2, {3'h0, mir_w[i]} + 8'h01);
    end
    $display("medium width done");
    // writes only while no pulse or header is under way
    wr(FA, 16'h0040);
    settle();
    @(posedge i_core_clk);
    i_hdr_start <= 1'b1;
    @(posedge i_core_clk);
    i_hdr_start <= 1'b0;
    i_hdr_sym_done <= 1'b1;
    @(negedge i_core_clk);
    check({o_hdr_busy, o_hdr_left}, 7'h42);
    repeat (2) @(posedge i_core_clk);
    i_hdr_sym_done <= 1'b0;
    @(negedge i_core_clk);
    check({o_hdr_busy, o_hdr_left}, 7'h00);
    @(posedge i_core_clk);
    i_hdr_start <= 1'b1;
    i_hdr_mir <= 1'b1;
    @(posedge i_core_clk);
    i_hdr_start <= 1'b0;
    i_hdr_mir <= 1'b0;
    i_hdr_sym_done <= 1'b1;
    @(negedge i_core_clk);
    check({o_hdr_busy, o_hdr_left}, 7'h42);
    repeat (2) @(posedge i_core_clk);
    i_hdr_sym_done <= 1'b0;
    @(negedge i_core_clk);
    check({o_hdr_busy, o_hdr_left}, 7'h00);
    $display("header count done");
    m.light(8);
    repeat (10) @(negedge i_core_clk);
    check(16'(n_single * 2 + n_double), 16'h0002);
    m.light(9);
    repeat (10) @(negedge i_core_clk);
    check(16'(n_single * 2 + n_double), 16'h0003);
    $display("receive window done");
    complete_run();
  end
endmodule

`default_nettype wire
